// File: hdl/boot_option_decoder.sv
// Boot option decoder: samples straps at reset release, outputs boot type and PC
// Contract
// - Both straps high, codes 000/001/010 select serial loaders to scratchpad.
// - Both straps high, code 011 boots external memory, bus unit master, A0000000.
// - Both straps high, code 100 boots external memory, bus unit slave, A0000000.
// - Both straps high, code 110 starts directly in scratchpad at D4000000.
// - Break-in low, test-mode high, code 000 tristates all outputs.
// - Break-in low, test-mode high, code 001 goes via ROM to DE000000.
// - Break-in low, test-mode high, codes 010 to 111 reserved, device stopped.
// - Both straps low, every code reserved, device stops.
// - Break-in and test-mode straps are active low.
// - Boot ROM paths load PC with DFFFFFFC first; user entry comes later.
`timescale 1ns/1ps
module boot_option_decoder
    import boot_option_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic break_in_strap_n,
    input wire logic test_mode_strap_n,
    input wire logic [CFG_W-1:0] hw_boot_config,
    output logic boot_valid,
    output boot_type_t boot_type,
    output logic [PC_W-1:0] pc_start,
    output logic [PC_W-1:0] user_entry,
    output logic via_boot_rom,
    output logic cpu_run,
    output logic cpu_halt,
    output logic pads_tristate
);
    boot_sel_if sel ();

    load_state_t state_q;
    load_state_t state_d;
    logic brk_q;
    logic tm_q;
    logic [CFG_W-1:0] cfg_q;
    boot_type_t type_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] entry_q;
    logic rom_q;
    logic halt_q;
    logic tri_q;

    assign sel.break_in_n = brk_q;
    assign sel.test_mode_n = tm_q;
    assign sel.cfg = cfg_q;

    boot_table u_table (
        .sel(sel)
    );

    wire take_w = (state_q == ST_RESET);
    wire decode_w = (state_q == ST_SAMPLED);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                state_d = ST_SAMPLED;
            end
            ST_SAMPLED: begin
                state_d = sel.halt ? ST_HALT : ST_RUN;
            end
            default: begin
                state_d = state_q;
            end
        endcase
    end

    // Straps taken only in the first cycle after reset release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            brk_q <= 1'b1;
            tm_q <= 1'b1;
            cfg_q <= 3'h0;
        end else if (take_w) begin
            brk_q <= break_in_strap_n;
            tm_q <= test_mode_strap_n;
            cfg_q <= hw_boot_config;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_RESET;
            type_q <= BOOT_NONE;
            pc_q <= PC_NONE;
            entry_q <= PC_NONE;
            rom_q <= 1'b0;
            halt_q <= 1'b0;
            tri_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (decode_w) begin
                type_q <= sel.boot_type;
                pc_q <= sel.pc_start;
                entry_q <= sel.user_entry;
                rom_q <= sel.via_rom;
                halt_q <= sel.halt;
                tri_q <= sel.tristate;
            end
        end
    end

    assign boot_valid = (state_q == ST_RUN) || (state_q == ST_HALT);
    assign boot_type = type_q;
    assign pc_start = pc_q;
    assign user_entry = entry_q;
    assign via_boot_rom = rom_q;
    assign cpu_halt = halt_q;
    assign pads_tristate = tri_q;
    // Tristated chip does not execute either
    assign cpu_run = (state_q == ST_RUN) && !tri_q;
endmodule : boot_option_decoder

// File: hdl/boot_option_pkg.sv
// Package of boot option encodings, addresses, boot types and load states
package boot_option_pkg;

    localparam int CFG_W = 3;
    localparam int PC_W = 32;

    localparam logic [CFG_W-1:0] CFG_LOAD_ASYNC = 3'h0;
    localparam logic [CFG_W-1:0] CFG_LOAD_CAN = 3'h1;
    localparam logic [CFG_W-1:0] CFG_LOAD_SYNC = 3'h2;
    localparam logic [CFG_W-1:0] CFG_EXT_MASTER = 3'h3;
    localparam logic [CFG_W-1:0] CFG_EXT_SLAVE = 3'h4;
    localparam logic [CFG_W-1:0] CFG_RSVD_5 = 3'h5;
    localparam logic [CFG_W-1:0] CFG_SCRATCHPAD = 3'h6;
    localparam logic [CFG_W-1:0] CFG_STOP_7 = 3'h7;
    localparam logic [CFG_W-1:0] CFG_TRISTATE = 3'h0;
    localparam logic [CFG_W-1:0] CFG_EMULATOR = 3'h1;

    localparam logic [PC_W-1:0] PC_BOOT_ROM = 32'hDFFFFFFC;
    localparam logic [PC_W-1:0] PC_EXT_MEM = 32'hA0000000;
    localparam logic [PC_W-1:0] PC_SCRATCHPAD = 32'hD4000000;
    localparam logic [PC_W-1:0] PC_EMULATOR = 32'hDE000000;
    localparam logic [PC_W-1:0] PC_NONE = 32'h00000000;

    typedef enum logic [3:0] {
        BOOT_NONE = 4'h0,
        BOOT_LOAD_ASYNC = 4'h1,
        BOOT_LOAD_CAN = 4'h2,
        BOOT_LOAD_SYNC = 4'h3,
        BOOT_EXT_MASTER = 4'h4,
        BOOT_EXT_SLAVE = 4'h5,
        BOOT_SCRATCHPAD = 4'h6,
        BOOT_TRISTATE = 4'h7,
        BOOT_EMULATOR = 4'h8,
        BOOT_RESERVED = 4'h9,
        BOOT_STOP = 4'hA
    } boot_type_t;

    // Gray along reset -> sampled -> running
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_SAMPLED = 2'h1,
        ST_RUN = 2'h3,
        ST_HALT = 2'h2
    } load_state_t;

endpackage : boot_option_pkg

// File: hdl/boot_sel_if.sv
// Interface carrying the latched boot selection between modules
`timescale 1ns/1ps
interface boot_sel_if;
    import boot_option_pkg::*;
    logic break_in_n;
    logic test_mode_n;
    logic [CFG_W-1:0] cfg;
    boot_type_t boot_type;
    logic [PC_W-1:0] pc_start;
    logic [PC_W-1:0] user_entry;
    logic via_rom;
    logic halt;
    logic tristate;
    modport decoder (
        input break_in_n, test_mode_n, cfg,
        output boot_type, pc_start, user_entry, via_rom, halt, tristate
    );
    modport top (
        output break_in_n, test_mode_n, cfg,
        input boot_type, pc_start, user_entry, via_rom, halt, tristate
    );
endinterface : boot_sel_if

// File: hdl/boot_table.sv
// Combinational boot table lookup from latched straps
`timescale 1ns/1ps
module boot_table
    import boot_option_pkg::*;
(
    boot_sel_if.decoder sel
);
    function automatic boot_type_t decode_type(input logic brk_n, input logic tm_n,
                                               input logic [CFG_W-1:0] cfg);
        boot_type_t t;
        t = BOOT_STOP;
        if (brk_n && tm_n) begin
            case (cfg)
                CFG_LOAD_ASYNC: t = BOOT_LOAD_ASYNC;
                CFG_LOAD_CAN: t = BOOT_LOAD_CAN;
                CFG_LOAD_SYNC: t = BOOT_LOAD_SYNC;
                CFG_EXT_MASTER: t = BOOT_EXT_MASTER;
                CFG_EXT_SLAVE: t = BOOT_EXT_SLAVE;
                CFG_SCRATCHPAD: t = BOOT_SCRATCHPAD;
                CFG_RSVD_5: t = BOOT_RESERVED;
                default: t = BOOT_STOP;
            endcase
        end else if (!brk_n && tm_n) begin
            if (cfg == CFG_TRISTATE) begin
                t = BOOT_TRISTATE;
            end else if (cfg == CFG_EMULATOR) begin
                t = BOOT_EMULATOR;
            end else begin
                t = BOOT_STOP;
            end
        end else begin
            t = BOOT_STOP;
        end
        return t;
    endfunction : decode_type

    boot_type_t t_w;
    assign t_w = decode_type(sel.break_in_n, sel.test_mode_n, sel.cfg);
    assign sel.boot_type = t_w;

    wire rom_w = (t_w == BOOT_LOAD_ASYNC) || (t_w == BOOT_LOAD_CAN) ||
                 (t_w == BOOT_LOAD_SYNC) || (t_w == BOOT_EXT_MASTER) ||
                 (t_w == BOOT_EXT_SLAVE) || (t_w == BOOT_EMULATOR);
    assign sel.via_rom = rom_w;
    // Boot ROM paths start at the ROM entry
    assign sel.pc_start = rom_w ? PC_BOOT_ROM :
                          (t_w == BOOT_SCRATCHPAD) ? PC_SCRATCHPAD : PC_NONE;
    assign sel.user_entry = (t_w == BOOT_EXT_MASTER || t_w == BOOT_EXT_SLAVE) ? PC_EXT_MEM :
                            (t_w == BOOT_EMULATOR) ? PC_EMULATOR :
                            (t_w == BOOT_NONE || t_w == BOOT_TRISTATE ||
                             t_w == BOOT_RESERVED || t_w == BOOT_STOP) ? PC_NONE :
                            PC_SCRATCHPAD;
    // Reserved 101 is treated as a halt as well
    assign sel.halt = (t_w == BOOT_STOP) || (t_w == BOOT_RESERVED);
    assign sel.tristate = (t_w == BOOT_TRISTATE);
endmodule : boot_table

// File: testbench/boot_option_decoder_assertions.sv
// Checker of boot decode timing and selection
`timescale 1ns/1ps
module boot_option_decoder_assertions
    import boot_option_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic break_in_strap_n,
    input wire logic test_mode_strap_n,
    input wire logic [CFG_W-1:0] hw_boot_config,
    input wire logic boot_valid,
    input wire boot_type_t boot_type,
    input wire logic [PC_W-1:0] pc_start,
    input wire logic [PC_W-1:0] user_entry,
    input wire logic via_boot_rom,
    input wire logic cpu_run,
    input wire logic cpu_halt,
    input wire logic pads_tristate
);
    logic arm_q;
    logic [4:0] cap_q;
    // Copy of the straps as seen at reset release
    always_ff @(posedge clk) begin
        arm_q <= sys_rst;
        if (arm_q && !sys_rst) cap_q <= {break_in_strap_n, test_mode_strap_n, hw_boot_config};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wait_s;
        !boot_valid ##1 !boot_valid ##1 boot_valid;
    endsequence
    valid_late_a: assert property ($fell(sys_rst) |-> wait_s)
        else $error("decode timing wrong");
    valid_hold_a: assert property (boot_valid |=> boot_valid && $stable(pc_start))
        else $error("decode not held");
    rom_pc_a: assert property (boot_valid && via_boot_rom |-> pc_start == PC_BOOT_ROM)
        else $error("rom start wrong");
    loader_a: assert property (boot_valid && cap_q inside {5'h18, 5'h19, 5'h1A}
        |-> cpu_run && user_entry == PC_SCRATCHPAD) else $error("loader wrong");
    ext_mem_a: assert property (boot_valid && cap_q inside {5'h1B, 5'h1C}
        |-> via_boot_rom && user_entry == PC_EXT_MEM) else $error("ext boot wrong");
    scratch_a: assert property (boot_valid && cap_q == 5'h1E
        |-> pc_start == PC_SCRATCHPAD && !via_boot_rom) else $error("scratch wrong");
    tristate_a: assert property (boot_valid && cap_q == 5'h08
        |-> pads_tristate && !cpu_run) else $error("tristate wrong");
    emul_a: assert property (boot_valid && cap_q == 5'h09
        |-> via_boot_rom && user_entry == PC_EMULATOR) else $error("emulator wrong");
    stop_dev_a: assert property (boot_valid && (cap_q[4:3] == 2'h0 || cap_q == 5'h1F
        || (cap_q[4:3] == 2'h1 && cap_q[2:1] != 2'h0)) |-> cpu_halt && !cpu_run)
        else $error("stop wrong");
endmodule : boot_option_decoder_assertions
bind boot_option_decoder boot_option_decoder_assertions boot_option_decoder_assertions_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .break_in_strap_n(break_in_strap_n),
    .test_mode_strap_n(test_mode_strap_n),
    .hw_boot_config(hw_boot_config),
    .boot_valid(boot_valid),
    .boot_type(boot_type),
    .pc_start(pc_start),
    .user_entry(user_entry),
    .via_boot_rom(via_boot_rom),
    .cpu_run(cpu_run),
    .cpu_halt(cpu_halt),
    .pads_tristate(pads_tristate)
);

// File: testbench/boot_option_decoder_tb.sv
// Testbench for the boot option decoder
`timescale 1ns/1ps
module boot_option_decoder_tb;
    import boot_option_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] want = 5'h1F;
    logic [4:0] pins;
    logic boot_valid, via_boot_rom, cpu_run, cpu_halt, pads_tristate;
    boot_type_t boot_type;
    logic [PC_W-1:0] pc_start, user_entry;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    boot_type_t hi_t [8] = '{BOOT_LOAD_ASYNC, BOOT_LOAD_CAN, BOOT_LOAD_SYNC,
        BOOT_EXT_MASTER, BOOT_EXT_SLAVE, BOOT_RESERVED, BOOT_SCRATCHPAD, BOOT_STOP};
    initial forever #25 clk = ~clk;
    strap_model strap_model_i (.clk(clk), .sys_rst(sys_rst), .want(want), .pins(pins));
    boot_option_decoder boot_option_decoder_i (.clk(clk), .sys_rst(sys_rst),
        .break_in_strap_n(pins[4]), .test_mode_strap_n(pins[3]), .hw_boot_config(pins[2:0]),
        .boot_valid(boot_valid), .boot_type(boot_type), .pc_start(pc_start),
        .user_entry(user_entry), .via_boot_rom(via_boot_rom), .cpu_run(cpu_run),
        .cpu_halt(cpu_halt), .pads_tristate(pads_tristate));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic run(input logic [4:0] s);
        boot_type_t t;
        logic h, z;
        logic [31:0] p, u;
        t = BOOT_STOP;
        if (s[4:3] == 2'h3) t = hi_t[s[2:0]];
        if (s[4:1] == 4'h4) t = s[0] ? BOOT_EMULATOR : BOOT_TRISTATE;
        h = t inside {BOOT_STOP, BOOT_RESERVED};
        z = t == BOOT_TRISTATE;
        p = t == BOOT_SCRATCHPAD ? PC_SCRATCHPAD : (h || z) ? PC_NONE : PC_BOOT_ROM;
        u = t inside {BOOT_EXT_MASTER, BOOT_EXT_SLAVE} ? PC_EXT_MEM :
            t == BOOT_EMULATOR ? PC_EMULATOR : p != PC_NONE ? PC_SCRATCHPAD : PC_NONE;
        @(negedge clk);
        want = s;
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check("valid early", 32'h0, 32'(boot_valid));
        @(negedge clk);
        check("valid", 32'h1, 32'(boot_valid));
        @(negedge clk);
        check("type", 32'(t), 32'(boot_type));
        check("pc", p, pc_start);
        check("user", u, user_entry);
        check("rom", 32'(p == PC_BOOT_ROM), 32'(via_boot_rom));
        check("halt", 32'(h), 32'(cpu_halt));
        check("run", 32'(!h && !z), 32'(cpu_run));
        check("tri", 32'(z), 32'(pads_tristate));
        // Straps are now inverted and held; the decode must not follow them
        repeat (3) @(negedge clk);
        check("type held", 32'(t), 32'(boot_type));
        check("pc held", p, pc_start);
        check("halt held", 32'(h), 32'(cpu_halt));
    endtask : run
    task automatic t_normal();
        for (int c = 0; c < 8; c++) run({2'h3, c[2:0]});
    endtask : t_normal
    task automatic t_break();
        for (int c = 0; c < 8; c++) run({2'h1, c[2:0]});
    endtask : t_break
    task automatic t_both_low();
        for (int c = 0; c < 8; c++) run({2'h0, c[2:0]});
        // Test-mode alone asserted decodes as BOOT_STOP and stops
        for (int c = 0; c < 8; c++) run({2'h2, c[2:0]});
    endtask : t_both_low
    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        t_normal();
        t_break();
        t_both_low();
        results();
    end
endmodule : boot_option_decoder_tb

// File: testbench/strap_model.sv
// Board strap model: straps held through reset, then inverted and held
`timescale 1ns/1ps
module strap_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] want,
    output logic [4:0] pins
);
    logic [1:0] cnt_q = 2'h0;
    always @(posedge clk) cnt_q <= sys_rst ? 2'h0 : (cnt_q == 2'h3 ? cnt_q : cnt_q + 2'h1);
    // Active-low levels held until sampled, inverted afterwards
    always @(negedge clk) pins <= (cnt_q < 2'h2) ? want : ~want;
endmodule : strap_model
